// ==== wbs_pkg.sv ====
/*
  Constants for the windowed burst sequencer: register map, fields, states.
  Assumes a single 10 MHz clock and a plain strobe register port.
*/
package wbs_pkg;
  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_WIN     = 8'h04;
  localparam logic [7:0] REG_ROWS    = 8'h08;
  localparam logic [7:0] REG_EXPO    = 8'h0C;
  localparam logic [7:0] REG_CLEAN   = 8'h10;
  localparam logic [7:0] REG_CYCLES  = 8'h14;
  localparam logic [7:0] REG_TOTAL   = 8'h18;
  localparam logic [7:0] REG_COLS    = 8'h1C;
  localparam logic [7:0] REG_STATUS  = 8'h20;
  localparam logic [7:0] REG_SUBF    = 8'h24;
  localparam logic [7:0] REG_IRQ_ST  = 8'h28;
  localparam logic [7:0] REG_IRQ_EN  = 8'h2C;
  localparam logic [7:0] REG_IRQ_CLR = 8'h30;
  localparam logic [7:0] REG_SWTRIG  = 8'h34;
  // ==========================================================
  // Control fields
  localparam int CTRL_START   = 0;
  localparam int CTRL_SHIFT   = 1;
  localparam int CTRL_EXTSRC  = 2;
  localparam int CTRL_BIN2    = 3;
  // Interrupt status bits
  localparam int IRQ_DONE     = 0;
  localparam int IRQ_MISMATCH = 1;
  localparam int IRQ_NUM      = 2;
  // ==========================================================
  // Reset values
  localparam logic [15:0] WIN_RST    = 16'h000A;
  localparam logic [15:0] ROWS_RST   = 16'h0800;
  localparam logic [15:0] EXPO_RST   = 16'h000A;
  localparam logic [15:0] CLEAN_RST  = 16'h0010;
  localparam logic [15:0] CYCLES_RST = 16'h0004;
  localparam logic [15:0] TOTAL_RST  = 16'h00CC;
  localparam logic [15:0] COLS_RST   = 16'h0010;
  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    WBS_IDLE, WBS_CLEAN, WBS_ARM, WBS_EXPOSE, WBS_SHIFT, WBS_READ
  } wbs_state_t;
endpackage : wbs_pkg

// ==== wbs_sensor_model.sv ====
/*
  Behavioural sensor: a pixel counter behind the serial register.
  Assumes pix_shift_in is a one-cycle strobe from the sequencer.
*/
`timescale 1ns/1ps
module wbs_sensor_model (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  // Serial register
  input  wire logic        pix_shift_in,
  output logic      [15:0] sense_data_out
);
  // ==========================================================
  // Pixel source
  // Rising values make lost or swapped pixels visible
  logic [15:0] pix_q;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) pix_q <= 16'h0001;
    else if (pix_shift_in) pix_q <= pix_q + 16'h0001;
  end
  // Strobe shows the next pixel in its own cycle: sampled every cycle
  assign sense_data_out = pix_q + {15'h0000, pix_shift_in};
endmodule // wbs_sensor_model

// ==== wbs_seq_properties.sv ====
/*
  Port-level checker for the burst sequencer, with shadow copies of config.
  Assumes it is bound to wbs_sequencer and the register map of wbs_pkg.
*/
`timescale 1ns/1ps
module wbs_seq_properties (
  // Clock, reset, register port
  input wire logic        clk_in,
  input wire logic        rst_b_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  // Sensor and stream
  input wire logic        row_shift_out,
  input wire logic        pix_shift_out,
  input wire logic        expose_out,
  input wire logic        pix_valid_out,
  input wire logic        frame_end_out,
  input wire logic        irq_out
);
  // ==========================================================
  // Shadow configuration
  logic [15:0] win_q, rows_q, expo_q, tot_q, ecnt_q;
  wire logic [15:0] subf = (win_q == 16'h0) ? 16'h0 : rows_q / win_q;
  // Guard keeps the modulo away from a zero divisor
  wire logic mism = (subf == 16'h0) ? 1'b1 : ((tot_q % subf) != 16'h0);
  wire logic wr_win = reg_wr_in && (reg_addr_in == wbs_pkg::REG_WIN);
  wire logic wr_rows = reg_wr_in && (reg_addr_in == wbs_pkg::REG_ROWS);
  wire logic wr_expo = reg_wr_in && (reg_addr_in == wbs_pkg::REG_EXPO);
  wire logic wr_tot = reg_wr_in && (reg_addr_in == wbs_pkg::REG_TOTAL);
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      win_q <= wbs_pkg::WIN_RST;
      rows_q <= wbs_pkg::ROWS_RST;
      expo_q <= wbs_pkg::EXPO_RST;
      tot_q <= wbs_pkg::TOTAL_RST;
      ecnt_q <= 16'h0000;
    end else begin
      ecnt_q <= expose_out ? ecnt_q + 16'h0001 : 16'h0000;
      if (wr_win) win_q <= reg_wdata_in[15:0];
      if (wr_rows) rows_q <= reg_wdata_in[15:0];
      if (wr_expo) expo_q <= reg_wdata_in[15:0];
      if (wr_tot) tot_q <= reg_wdata_in[15:0];
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  property p_rd_idle; !reg_rd_in |=> reg_rdata_out == 32'h0000_0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
  property p_unmapped; reg_rd_in && reg_addr_in == 8'h3C |=> reg_rdata_out == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_subf;
    reg_rd_in && reg_addr_in == wbs_pkg::REG_SUBF |=> reg_rdata_out == {16'h0, $past(subf, 2)};
  endproperty
  a_subf: assert property (p_subf) else $error("subframe count wrong");
  property p_mism;
    reg_rd_in && reg_addr_in == wbs_pkg::REG_STATUS |=> reg_rdata_out[3] == $past(mism, 2);
  endproperty
  a_mism: assert property (p_mism) else $error("mismatch flag wrong");
  property p_expo; $fell(expose_out) |-> ecnt_q == expo_q; endproperty
  a_expo: assert property (p_expo) else $error("exposure length wrong");
  property p_quiet; expose_out |-> !row_shift_out && !pix_shift_out && !pix_valid_out; endproperty
  a_quiet: assert property (p_quiet) else $error("shift during exposure");
  property p_fe; frame_end_out |=> !frame_end_out; endproperty
  a_fe: assert property (p_fe) else $error("frame end longer than a cycle");
  property p_irq_off;
    reg_wr_in && reg_addr_in == wbs_pkg::REG_IRQ_EN && reg_wdata_in[1:0] == 2'b00 |-> ##2 !irq_out;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("masked interrupt still high");
  c_done: cover property ($rose(irq_out));
  c_fe: cover property (frame_end_out);
  c_expo: cover property ($fell(expose_out));
endmodule // wbs_seq_properties
bind wbs_sequencer wbs_seq_properties u_props (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .row_shift_out(row_shift_out),
  .pix_shift_out(pix_shift_out), .expose_out(expose_out),
  .pix_valid_out(pix_valid_out), .frame_end_out(frame_end_out), .irq_out(irq_out));

// ==== wbs_sequencer.sv ====
/*
  Windowed burst (kinetics) sequencer: cleaning, exposure-shift series,
  readout of stored subframes with optional 2-row binning.
  Assumes one 10 MHz clock; the external trigger is an asynchronous pin.
  The sensor is driven by one-row vertical shift and one-pixel serial
  shift strobes; pixel data arrive on sense_data_in.
*/
`timescale 1ns/1ps
// Functional notes
// RULE1: In single-trigger mode one trigger starts the whole exposure-shift series.
// RULE2: In single-trigger mode each exposure lasts the programmed exposure time.
// RULE3: In per-shift mode each trigger pulse runs exactly one exposure-shift cycle.
// RULE4: After the programmed cycles all stored subframes are read out to the host.
// RULE5: Readout may bin row pairs in hardware to shorten it.
// RULE6: Before the first trigger the sensor is cleaned one row at a time.
// RULE7: A clean count of zero means no cleaning before the first trigger.
// RULE8: Subframes per readout derive from window height and follow its changes.
// RULE9: A warning flags when total frames are not a multiple of subframes per readout.
// RULE10: Software should request total frames as a multiple of subframes per readout.
// RULE11: Trigger response is one of two: single per burst or one per shift cycle.
// RULE12: The trigger comes from the internal source or the external pin.
// RULE13: The exposed window is a count of rows; the rest is masked storage.
// RULE14: Each cycle shifts the charge down by the window height in rows.
// RULE15: Subframes go to the host in acquisition order, pixel by pixel.
module wbs_sequencer (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  // Register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  // Trigger pin
  input  wire logic        ext_trig_in,
  // Sensor drive
  output logic             row_shift_out,
  output logic             pix_shift_out,
  output logic             expose_out,
  input  wire logic [15:0] sense_data_in,
  // Pixel stream to host
  output logic [15:0]      pix_data_out,
  output logic             pix_valid_out,
  output logic             frame_end_out,
  // Interrupt
  output logic             irq_out
);
  // ==========================================================
  // Registers
  logic [3:0]  ctrl_q;
  logic [15:0] win_q, rows_q, expo_q, clean_q, cycles_q, total_q, cols_q;
  localparam int IRQ_NUM = wbs_pkg::IRQ_NUM;
  logic [IRQ_NUM-1:0] irq_st_q, irq_en_q;
  logic        swtrig_q;
  logic [15:0] subf_q;
  logic        mism_q;
  // ==========================================================
  // Sequencer state
  wbs_pkg::wbs_state_t state_q;
  logic [15:0] cnt_q;        // exposure timer, cleared at shift end
  logic [15:0] rowin_q;      // rows shifted in this cycle or subframe
  logic [15:0] cyc_q;        // completed exposure-shift cycles
  logic [15:0] sub_q;        // subframes read
  logic [15:0] col_q;
  logic [15:0] cleaned_q;
  logic [2:0]  trig_sync_q;
  logic        trig_lvl_q;
  logic        bin_ph_q;
  logic        done_pulse_q;

  // ==========================================================
  // Decode
  wire wr_ctrl   = reg_wr_in && reg_addr_in == wbs_pkg::REG_CTRL;
  wire wr_win    = reg_wr_in && reg_addr_in == wbs_pkg::REG_WIN;
  wire wr_rows   = reg_wr_in && reg_addr_in == wbs_pkg::REG_ROWS;
  wire wr_expo   = reg_wr_in && reg_addr_in == wbs_pkg::REG_EXPO;
  wire wr_clean  = reg_wr_in && reg_addr_in == wbs_pkg::REG_CLEAN;
  wire wr_cycles = reg_wr_in && reg_addr_in == wbs_pkg::REG_CYCLES;
  wire wr_total  = reg_wr_in && reg_addr_in == wbs_pkg::REG_TOTAL;
  wire wr_cols   = reg_wr_in && reg_addr_in == wbs_pkg::REG_COLS;
  wire wr_irq_en = reg_wr_in && reg_addr_in == wbs_pkg::REG_IRQ_EN;
  wire wr_irqclr = reg_wr_in && reg_addr_in == wbs_pkg::REG_IRQ_CLR;
  wire wr_swtrig = reg_wr_in && reg_addr_in == wbs_pkg::REG_SWTRIG;

  // Trigger select: external edge once two late stages agree
  wire ext_rise = trig_sync_q[2] && trig_sync_q[1] && !trig_lvl_q;
  wire trig     = ctrl_q[wbs_pkg::CTRL_EXTSRC] ? ext_rise : swtrig_q; // RULE12
  wire shift_md = ctrl_q[wbs_pkg::CTRL_SHIFT];                        // RULE11
  wire bin2     = ctrl_q[wbs_pkg::CTRL_BIN2];

  // Subframes per readout: storage depth over window height
  wire [15:0] subf_d = (win_q == 16'h0000) ? 16'h0000 : rows_q / win_q; // RULE8
  // Fresh quotient, so the flag moves in the same cycle as the count
  wire [15:0] rem_d  = (subf_d == 16'h0000) ? 16'h0000 : total_q % subf_d;
  wire        mism_d = (subf_d == 16'h0000) || (rem_d != 16'h0000);  // RULE9
  wire        mism_rise = mism_d && !mism_q;

  // Row counts used per subframe, halved under binning
  wire [15:0] rows_per_sub = bin2 ? {1'b0, win_q[15:1]} : win_q;     // RULE5
  wire        exp_done  = cnt_q + 16'h0001 >= expo_q;                // RULE2
  wire        shift_end = rowin_q + 16'h0001 >= win_q;               // RULE14
  wire        line_end  = col_q + 16'h0001 >= cols_q;
  wire        sub_end   = rowin_q + 16'h0001 >= rows_per_sub;
  wire        all_read  = sub_q + 16'h0001 >= cyc_q;
  wire        row_step  = state_q == wbs_pkg::WBS_READ && line_end && !bin_ph_q;
  wire        clean_on  = clean_q != 16'h0000;                        // RULE7
  wire        clean_last = cleaned_q + 16'h0001 >= clean_q;
  // Single-trigger series re-arms itself after each shift
  wire        auto_go   = !shift_md && cyc_q != 16'h0000;            // RULE1

  // Read mux
  logic [31:0] rd_mux;
  always_comb begin
    case (reg_addr_in)
      wbs_pkg::REG_CTRL:   rd_mux = {28'h0000000, ctrl_q};
      wbs_pkg::REG_WIN:    rd_mux = {16'h0000, win_q};
      wbs_pkg::REG_ROWS:   rd_mux = {16'h0000, rows_q};
      wbs_pkg::REG_EXPO:   rd_mux = {16'h0000, expo_q};
      wbs_pkg::REG_CLEAN:  rd_mux = {16'h0000, clean_q};
      wbs_pkg::REG_CYCLES: rd_mux = {16'h0000, cycles_q};
      wbs_pkg::REG_TOTAL:  rd_mux = {16'h0000, total_q};
      wbs_pkg::REG_COLS:   rd_mux = {16'h0000, cols_q};
      wbs_pkg::REG_STATUS: rd_mux = {12'h000, cyc_q, mism_q, state_q};
      wbs_pkg::REG_SUBF:   rd_mux = {16'h0000, subf_q};
      wbs_pkg::REG_IRQ_ST: rd_mux = {30'h00000000, irq_st_q};
      wbs_pkg::REG_IRQ_EN: rd_mux = {30'h00000000, irq_en_q};
      default:             rd_mux = 32'h00000000;
    endcase
  end

  // ==========================================================
  // Register file
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_q   <= 4'h0;
      win_q    <= wbs_pkg::WIN_RST;
      rows_q   <= wbs_pkg::ROWS_RST;
      expo_q   <= wbs_pkg::EXPO_RST;
      clean_q  <= wbs_pkg::CLEAN_RST;
      cycles_q <= wbs_pkg::CYCLES_RST;
      total_q  <= wbs_pkg::TOTAL_RST;
      cols_q   <= wbs_pkg::COLS_RST;
      irq_en_q <= 2'h0;
      swtrig_q <= 1'b0;
      reg_rdata_out <= 32'h00000000;
    end else begin
      if (wr_ctrl)   ctrl_q   <= reg_wdata_in[3:0];
      else if (state_q != wbs_pkg::WBS_IDLE) ctrl_q[wbs_pkg::CTRL_START] <= 1'b0;
      if (wr_win)    win_q    <= reg_wdata_in[15:0];                 // RULE13
      if (wr_rows)   rows_q   <= reg_wdata_in[15:0];
      if (wr_expo)   expo_q   <= reg_wdata_in[15:0];
      if (wr_clean)  clean_q  <= reg_wdata_in[15:0];
      if (wr_cycles) cycles_q <= reg_wdata_in[15:0];
      if (wr_total)  total_q  <= reg_wdata_in[15:0];
      if (wr_cols)   cols_q   <= reg_wdata_in[15:0];
      if (wr_irq_en) irq_en_q <= reg_wdata_in[1:0];
      swtrig_q <= wr_swtrig && reg_wdata_in[0];
      reg_rdata_out <= reg_rd_in ? rd_mux : 32'h00000000;
    end
  end

  // Derived counts and sticky events; a set wins over a clear
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      subf_q   <= wbs_pkg::ROWS_RST / wbs_pkg::WIN_RST;
      mism_q   <= 1'b0;
      irq_st_q <= 2'h0;
      irq_out  <= 1'b0;
    end else begin
      subf_q   <= subf_d;                                            // RULE8
      mism_q   <= mism_d;
      irq_st_q <= (irq_st_q & ~(wr_irqclr ? reg_wdata_in[1:0] : 2'h0))
                  | {mism_rise, done_pulse_q};                       // RULE9
      irq_out  <= |(irq_st_q & irq_en_q);
    end
  end

  // Trigger pin synchroniser
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      trig_sync_q <= 3'h0;
      trig_lvl_q  <= 1'b0;
    end else begin
      trig_sync_q <= {trig_sync_q[1:0], ext_trig_in};
      if (trig_sync_q[2] == trig_sync_q[1]) trig_lvl_q <= trig_sync_q[2];
    end
  end

  // ==========================================================
  // Sequencer
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= wbs_pkg::WBS_IDLE;
      cnt_q <= 16'h0000;
      rowin_q <= 16'h0000;
      cyc_q <= 16'h0000;
      sub_q <= 16'h0000;
      col_q <= 16'h0000;
      cleaned_q <= 16'h0000;
      bin_ph_q <= 1'b0;
      done_pulse_q <= 1'b0;
      row_shift_out <= 1'b0;
      pix_shift_out <= 1'b0;
      expose_out <= 1'b0;
      pix_data_out <= 16'h0000;
      pix_valid_out <= 1'b0;
      frame_end_out <= 1'b0;
    end else begin
      row_shift_out <= 1'b0;
      pix_shift_out <= 1'b0;
      pix_valid_out <= 1'b0;
      frame_end_out <= 1'b0;
      done_pulse_q <= 1'b0;
      case (state_q)
        wbs_pkg::WBS_IDLE: begin
          cyc_q <= 16'h0000;
          cleaned_q <= 16'h0000;
          if (ctrl_q[wbs_pkg::CTRL_START]) begin
            // Zero clean count skips straight to waiting
            state_q <= clean_on ? wbs_pkg::WBS_CLEAN : wbs_pkg::WBS_ARM; // RULE7
          end
        end
        wbs_pkg::WBS_CLEAN: begin
          // Jitter is one row shift: trigger is seen between row strobes
          if (trig) begin
            state_q <= wbs_pkg::WBS_EXPOSE;                          // RULE1 RULE3
            cnt_q <= 16'h0000;
            expose_out <= 1'b1;
          end else begin
            row_shift_out <= 1'b1;                                   // RULE6
            cleaned_q <= cleaned_q + 16'h0001;
            if (clean_last) state_q <= wbs_pkg::WBS_ARM;
          end
        end
        wbs_pkg::WBS_ARM: begin
          // Exposure opens a cycle after the last shift, never beside it
          if (trig || auto_go) begin
            state_q <= wbs_pkg::WBS_EXPOSE;                          // RULE1 RULE3
            cnt_q <= 16'h0000;
            expose_out <= 1'b1;
          end
        end
        wbs_pkg::WBS_EXPOSE: begin
          cnt_q <= cnt_q + 16'h0001;
          if (exp_done) begin                                        // RULE2
            expose_out <= 1'b0;
            rowin_q <= 16'h0000;
            state_q <= wbs_pkg::WBS_SHIFT;
          end
        end
        wbs_pkg::WBS_SHIFT: begin
          row_shift_out <= 1'b1;                                     // RULE14
          rowin_q <= rowin_q + 16'h0001;
          if (shift_end) begin
            cyc_q <= cyc_q + 16'h0001;
            cnt_q <= 16'h0000;
            if (cyc_q + 16'h0001 >= cycles_q) begin                  // RULE4
              state_q <= wbs_pkg::WBS_READ;
              sub_q <= 16'h0000;
              rowin_q <= 16'h0000;
              col_q <= 16'h0000;
              bin_ph_q <= bin2;                                      // RULE5
            end else begin
              // Per-shift mode waits here; single mode leaves next cycle
              state_q <= wbs_pkg::WBS_ARM;                           // RULE1 RULE3
            end
          end
        end
        wbs_pkg::WBS_READ: begin
          if (bin_ph_q) begin
            // Second row of a pair joins the serial register unread
            row_shift_out <= 1'b1;                                   // RULE5
            bin_ph_q <= 1'b0;
          end else begin
            // Oldest subframe is nearest the serial register: order is kept
            pix_shift_out <= 1'b1;                                   // RULE15
            pix_data_out <= sense_data_in;
            pix_valid_out <= 1'b1;
            col_q <= line_end ? 16'h0000 : col_q + 16'h0001;
          end
          if (row_step) begin
            row_shift_out <= 1'b1;
            bin_ph_q <= bin2;                                        // RULE5
            rowin_q <= sub_end ? 16'h0000 : rowin_q + 16'h0001;
            if (sub_end) begin
              frame_end_out <= 1'b1;                                 // RULE15
              sub_q <= sub_q + 16'h0001;
              if (all_read) begin                                    // RULE4
                state_q <= wbs_pkg::WBS_IDLE;
                done_pulse_q <= 1'b1;
              end
            end
          end
        end
        default: state_q <= wbs_pkg::WBS_IDLE;
      endcase
    end
  end
endmodule // wbs_sequencer

// ==== windowed_ccd_burst_sequencer_tb.sv ====
/*
  Self-checking bench for the burst sequencer with a counting sensor.
  Assumes the wbs_pkg register map, one 10 MHz clock, reset held 6 cycles.
*/
`timescale 1ns/1ps
module windowed_ccd_burst_sequencer_tb;
  localparam int WIN = 4;
  localparam int CYC = 2;
  localparam int COLS = 3;
  localparam int EXPO = 5;
  localparam int CLN = 3;
  logic        clk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic        wr = 1'b0, rd = 1'b0, ext = 1'b0;
  logic        row_s, pix_s, expo_s, pvalid, fend, irq;
  logic [15:0] sense, pdata, last_pix = 16'h0000;
  int          n_row = 0, n_pix = 0, n_fe = 0, n_exp = 0, failures = 0, num_checks = 0;
  always #50 clk_in = ~clk_in;
  wbs_sequencer DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .ext_trig_in(ext), .row_shift_out(row_s), .pix_shift_out(pix_s), .expose_out(expo_s),
    .sense_data_in(sense), .pix_data_out(pdata), .pix_valid_out(pvalid),
    .frame_end_out(fend), .irq_out(irq));
  wbs_sensor_model u_sensor (.clk_in(clk_in), .rst_b_in(rst_b_in), .pix_shift_in(pix_s),
    .sense_data_out(sense));
  // ==========================================================
  // Tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic conclude;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr <= a; rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    @(negedge clk_in);
    d = rdata;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] d;
    rd_reg(a, d);
    chk(n, e, d);
  endtask
  task automatic chk_irq(input logic e);
    @(posedge clk_in);
    @(negedge clk_in);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask
  task automatic wait_st(input logic [2:0] s);
    logic [31:0] d;
    for (int i = 0; i < 300; i++) begin
      rd_reg(wbs_pkg::REG_STATUS, d);
      if (d[2:0] === s) return;
    end
    chk("state wait", {29'h0, s}, d);
    conclude();
  endtask
  task automatic wait_irq;
    for (int i = 0; i < 3000; i++) begin
      @(negedge clk_in);
      if (irq === 1'b1) return;
    end
    chk("irq wait", 32'h1, 32'h0);
    conclude();
  endtask
  task automatic wait_rows(input int n);
    for (int i = 0; i < 500 && n_row < n; i++) @(posedge clk_in);
    repeat (3) @(negedge clk_in);
    if (n_row < n) begin
      chk("row wait", n, n_row);
      conclude();
    end
  endtask
  task automatic ext_pulse;
    @(posedge clk_in);
    ext <= 1'b1;
    repeat (4) @(posedge clk_in);
    ext <= 1'b0;
  endtask
  task automatic zero;
    @(negedge clk_in);
    n_row = 0; n_pix = 0; n_fe = 0; n_exp = 0;
  endtask
  // ==========================================================
  // Monitor
  always @(posedge clk_in) begin
    n_row <= n_row + (row_s === 1'b1);
    n_exp <= n_exp + (expo_s === 1'b1);
    n_fe <= n_fe + (fend === 1'b1);
    n_pix <= n_pix + (pvalid === 1'b1);
    if (pvalid === 1'b1) begin
      chk("pixel order", 32'h1, {31'h0, pdata > last_pix});
      last_pix <= pdata;
    end
  end
  // ==========================================================
  // Sequence
  initial begin
    repeat (6) @(posedge clk_in);
    rst_b_in <= 1'b1;
    chk_rd(wbs_pkg::REG_WIN, {16'h0, wbs_pkg::WIN_RST}, "win reset");
    chk_rd(wbs_pkg::REG_SUBF, {16'h0, wbs_pkg::ROWS_RST / wbs_pkg::WIN_RST}, "subf");
    chk_rd(wbs_pkg::REG_STATUS, 32'h0, "status reset");
    chk_rd(8'h3C, 32'h0, "unmapped");
    wr_reg(wbs_pkg::REG_WIN, WIN);
    wr_reg(wbs_pkg::REG_ROWS, 2 * WIN);
    wr_reg(wbs_pkg::REG_EXPO, EXPO);
    wr_reg(wbs_pkg::REG_CLEAN, CLN);
    wr_reg(wbs_pkg::REG_CYCLES, CYC);
    wr_reg(wbs_pkg::REG_TOTAL, 3);
    wr_reg(wbs_pkg::REG_COLS, COLS);
    chk_rd(wbs_pkg::REG_SUBF, 2, "subf");
    rd_reg(wbs_pkg::REG_STATUS, v);
    chk("mismatch", 32'h1, {31'h0, v[3]});
    wr_reg(wbs_pkg::REG_IRQ_EN, 3);
    chk_irq(1'b1);
    wr_reg(wbs_pkg::REG_TOTAL, 4);
    wr_reg(wbs_pkg::REG_WIN, 2);
    chk_rd(wbs_pkg::REG_SUBF, 4, "subf");
    wr_reg(wbs_pkg::REG_WIN, WIN);
    rd_reg(wbs_pkg::REG_STATUS, v);
    chk("mismatch", 32'h0, {31'h0, v[3]});
    wr_reg(wbs_pkg::REG_IRQ_CLR, 3);
    chk_rd(wbs_pkg::REG_IRQ_ST, 32'h0, "irq status");
    chk_irq(1'b0);
    // Single trigger, internal source, no binning
    zero();
    wr_reg(wbs_pkg::REG_CTRL, 1);
    wait_rows(CLN);
    chk("clean rows", CLN, n_row);
    wr_reg(wbs_pkg::REG_SWTRIG, 1);
    wait_irq();
    chk("expose cycles", EXPO * CYC, n_exp);
    chk("row shifts", CLN + 2 * WIN * CYC, n_row);
    chk("pixels", COLS * WIN * CYC, n_pix);
    chk("subframes", CYC, n_fe);
    chk_rd(wbs_pkg::REG_IRQ_ST, 32'h1, "done");
    wr_reg(wbs_pkg::REG_IRQ_CLR, 1);
    wr_reg(wbs_pkg::REG_CTRL, 0);
    // Per-shift trigger, external source, binning, no cleaning
    wr_reg(wbs_pkg::REG_CLEAN, 0);
    zero();
    wr_reg(wbs_pkg::REG_CTRL, 32'hF);
    wait_st(wbs_pkg::WBS_ARM);
    wr_reg(wbs_pkg::REG_SWTRIG, 1);
    repeat (EXPO + 3) @(posedge clk_in);
    chk("internal ignored", 0, n_exp);
    chk("no clean", 0, n_row);
    ext_pulse();
    wait_rows(WIN);
    wait_st(wbs_pkg::WBS_ARM);
    chk("one expose", EXPO, n_exp);
    chk("one shift", WIN, n_row);
    ext_pulse();
    wait_irq();
    chk("binned pixels", COLS * (WIN / 2) * CYC, n_pix);
    chk("binned rows", 2 * WIN * CYC, n_row);
    chk("subframes", CYC, n_fe);
    wr_reg(wbs_pkg::REG_IRQ_EN, 0);
    chk_irq(1'b0);
    wr_reg(wbs_pkg::REG_IRQ_CLR, 3);
    chk_rd(wbs_pkg::REG_IRQ_ST, 32'h0, "irq status");
    conclude();
  end
endmodule // windowed_ccd_burst_sequencer_tb
